// File: rtl/scsi_msg_pkg.sv
package scsi_msg_pkg;
// What this block does
// - in message out drive cd and msg high, io low.
// - raised attention leads into message out when the target chooses.
// - unsupported message: go message in, send reject, return to message out.
// - retry mode: bad parity stays in message out; third failure drops to bus free.
// - after a parity drop hold sense key B with 43 03.
// - check mode: first bad parity message drops to bus free at once.
// - next command without sense request gets check condition with deferred flag.
// - bus reset overrides every phase and condition.
// - bus reset clears command, reservations and modes, then bus free.
// - acknowledged buffered write data survives bus reset and is still committed.
// - attention during selection leads to message out right after selection.
// - message codes keep their direction split; wrong-way codes are rejected.
// - after sending command complete enter bus free.
// - sync negotiation is five bytes: 01, 03, 01, period, offset.
// - only period codes from the rate table are returned, or 00 when the offset is zero.
// - proposal slower than one megabyte per second: reject and go asynchronous.
// - in message in drive cd, io and msg all high.
// - offset up to fifteen; smaller offsets adopted; zero means asynchronous.
// - bus device reset message clears command, reservations and modes like bus reset, then bus free.

   localparam logic [7:0] MSG_CMD_DONE = 8'h00;
   localparam logic [7:0] MSG_EXT = 8'h01;
   localparam logic [7:0] MSG_RESTORE = 8'h03;
   localparam logic [7:0] MSG_INIT_ERR = 8'h05;
   localparam logic [7:0] MSG_ABORT = 8'h06;
   localparam logic [7:0] MSG_REJECT = 8'h07;
   localparam logic [7:0] MSG_NOP = 8'h08;
   localparam logic [7:0] MSG_PAR_ERR = 8'h09;
   localparam logic [7:0] MSG_DEV_RESET = 8'h0C;
   localparam logic [7:0] EXT_LEN = 8'h03;
   localparam logic [7:0] EXT_SYNC = 8'h01;
   localparam logic [2:0] EXT_BYTES = 3'h5;
   localparam int IDENT_BIT = 7;
   localparam int IDENT_DISC_BIT = 6;
   localparam logic [7:0] IDENT_MASK = 8'hB8;
   localparam logic [7:0] IDENT_VAL = 8'h80;
   localparam logic [7:0] PERIOD_MAX = 8'hFA;
   localparam logic [3:0] OFFSET_MAX = 4'hF;
   localparam int PERIOD_CNT = 20;
   localparam logic [7:0] PERIOD_TAB [PERIOD_CNT] = '{8'h34, 8'h3E, 8'h48, 8'h53, 8'h5D,
      8'h68, 8'h72, 8'h7D, 8'h87, 8'h91, 8'h9C, 8'hA6, 8'hB1, 8'hBB, 8'hC6, 8'hD0,
      8'hDA, 8'hE5, 8'hEF, 8'hFA};
   localparam logic [1:0] RETRY_LIMIT = 2'h3;
   localparam logic [3:0] SENSE_KEY = 4'hB;
   localparam logic [7:0] SENSE_ASC = 8'h43;
   localparam logic [7:0] SENSE_ASCQ = 8'h03;
   // register map and field positions
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_SENSE = 8'h08;
   localparam int CTRL_RESV_BIT = 0;
   localparam int CTRL_SENSE_CLR_BIT = 1;
   localparam int STAT_BSY_BIT = 0;
   localparam int STAT_SENSE_BIT = 1;
   localparam int STAT_DISC_BIT = 2;
   localparam int STAT_RESV_BIT = 3;
   localparam int STAT_OFF_LSB = 8;
   localparam int STAT_PER_LSB = 16;
   localparam int STAT_LAST_LSB = 24;
   localparam int SENSE_ASC_LSB = 8;
   localparam int SENSE_ASCQ_LSB = 16;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_s;
   typedef struct packed {
      logic valid;
      logic par_ok;
      logic [7:0] data;
   } rx_byte_s;
   typedef struct packed {
      logic bsy;
      logic cd;
      logic io;
      logic msg;
   } phase_s;
   typedef enum logic [1:0] {ST_FREE, ST_CONN, ST_MSGO, ST_MSGI} state_e;
endpackage

// File: rtl/scsi_target_msg.sv
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module scsi_target_msg #(
   parameter int PEND_W = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire scsi_msg_pkg::apb_req_s apb_req,
   output scsi_msg_pkg::apb_rsp_s apb_rsp,
   input wire logic atn_pin,
   input wire logic bus_rst_pin,
   input wire logic parity_retry_pin,
   input wire logic sel_done,
   input wire logic cmd_complete,
   input wire logic new_cmd,
   input wire scsi_msg_pkg::rx_byte_s rx_byte,
   input wire logic tx_done,
   input wire logic wr_acked,
   input wire logic wr_written,
   output scsi_msg_pkg::phase_s phase,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic check_cond,
   output logic deferred,
   output logic abort_cmd,
   output logic commit_pending
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; first stage read only by the second
   logic atn_meta_ff, atn_ff, brst_meta_ff, brst_ff, prty_meta_ff, prty_ff;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         atn_meta_ff <= 1'b0;
         atn_ff <= 1'b0;
         brst_meta_ff <= 1'b0;
         brst_ff <= 1'b0;
         prty_meta_ff <= 1'b0;
         prty_ff <= 1'b0;
      end else begin
         atn_meta_ff <= atn_pin;
         atn_ff <= atn_meta_ff;
         brst_meta_ff <= bus_rst_pin;
         brst_ff <= brst_meta_ff;
         prty_meta_ff <= parity_retry_pin;
         prty_ff <= prty_meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // helpers: nearest table period not faster than asked, reply byte picker
   function automatic logic [7:0] round_period(input logic [7:0] p);
      logic [7:0] res;
      res = scsi_msg_pkg::PERIOD_MAX;
      for (int i = scsi_msg_pkg::PERIOD_CNT - 1; i >= 0; i--) begin
         if (scsi_msg_pkg::PERIOD_TAB[i] >= p) res = scsi_msg_pkg::PERIOD_TAB[i];
      end
      return res;
   endfunction

   function automatic logic [7:0] reply_byte(input logic ext, input logic [2:0] idx,
                                             input logic [7:0] single, input logic [7:0] per,
                                             input logic [3:0] off);
      logic [7:0] b;
      b = single;
      if (ext) begin
         case (idx)
            3'h0: b = scsi_msg_pkg::MSG_EXT;
            3'h1: b = scsi_msg_pkg::EXT_LEN;
            3'h2: b = scsi_msg_pkg::EXT_SYNC;
            3'h3: b = per;
            default: b = {4'h0, off};
         endcase
      end
      return b;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // message state and mode registers
   scsi_msg_pkg::state_e state_ff, nxt_state;
   logic [2:0] ext_idx_ff, nxt_ext_idx, tx_idx_ff, nxt_tx_idx, tx_len_ff, nxt_tx_len;
   logic [7:0] ext_per_ff, nxt_ext_per, tx_single_ff, nxt_tx_single;
   logic [7:0] per_ff, nxt_per, rx_last_ff, nxt_rx_last, last_tx_ff, nxt_last_tx;
   logic [3:0] off_ff, nxt_off;
   logic [1:0] retry_ff, nxt_retry;
   logic tx_ext_ff, nxt_tx_ext, disc_ok_ff, nxt_disc_ok, resv_ff, nxt_resv;
   logic sense_ff, nxt_sense;
   logic [PEND_W-1:0] pend_ff, nxt_pend;
   scsi_msg_pkg::phase_s nxt_phase;
   logic nxt_tx_valid, nxt_check, nxt_deferred, nxt_abort;
   logic [7:0] nxt_tx_data;
   logic bad_byte, good_byte, wr_hit, drop, start_tx, hard_clr, last_tx;
   logic [7:0] tx_pick;
   logic [3:0] off_pick;
   // retry count at which the next bad byte gives up the bus
   localparam logic [1:0] RETRY_LAST = scsi_msg_pkg::RETRY_LIMIT - 2'h1;

   // bad parity, decode and reply sequencing; bus reset is applied last so it wins
   always_comb begin
      nxt_state = state_ff;
      nxt_ext_idx = ext_idx_ff;
      nxt_ext_per = ext_per_ff;
      nxt_tx_idx = tx_idx_ff;
      nxt_tx_len = tx_len_ff;
      nxt_tx_ext = tx_ext_ff;
      nxt_tx_single = tx_single_ff;
      nxt_per = per_ff;
      nxt_off = off_ff;
      nxt_retry = retry_ff;
      nxt_rx_last = rx_last_ff;
      nxt_last_tx = last_tx_ff;
      nxt_disc_ok = disc_ok_ff;
      nxt_resv = resv_ff;
      nxt_sense = sense_ff;
      nxt_tx_valid = tx_valid;
      nxt_tx_data = tx_data;
      nxt_check = 1'b0;
      nxt_deferred = deferred;
      nxt_abort = 1'b0;
      drop = 1'b0;
      hard_clr = 1'b0;
      start_tx = 1'b0;
      tx_pick = scsi_msg_pkg::MSG_REJECT;
      off_pick = 4'h0;
      bad_byte = (state_ff == scsi_msg_pkg::ST_MSGO) && rx_byte.valid && !rx_byte.par_ok;
      good_byte = (state_ff == scsi_msg_pkg::ST_MSGO) && rx_byte.valid && rx_byte.par_ok;
      last_tx = tx_done && (tx_idx_ff == tx_len_ff - 3'h1);
      wr_hit = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready &&
               (apb_req.paddr == scsi_msg_pkg::REG_CTRL);
      // software owns reservation and acknowledges served sense data
      if (wr_hit) begin
         nxt_resv = apb_req.pwdata[scsi_msg_pkg::CTRL_RESV_BIT];
         if (apb_req.pwdata[scsi_msg_pkg::CTRL_SENSE_CLR_BIT]) begin
            nxt_sense = 1'b0;
            nxt_deferred = 1'b0;
         end
      end
      case (state_ff)
         scsi_msg_pkg::ST_FREE: begin
            if (sel_done) begin
               nxt_retry = 2'h0;
               if (atn_ff) nxt_state = scsi_msg_pkg::ST_MSGO;
               else nxt_state = scsi_msg_pkg::ST_CONN;
            end
         end
         scsi_msg_pkg::ST_CONN: begin
            if (cmd_complete) begin
               start_tx = 1'b1;
               tx_pick = scsi_msg_pkg::MSG_CMD_DONE;
            end else if (atn_ff) begin
               nxt_state = scsi_msg_pkg::ST_MSGO;
            end
         end
         scsi_msg_pkg::ST_MSGO: begin
            if (bad_byte) begin
               nxt_ext_idx = 3'h0;
               if (!prty_ff) drop = 1'b1;
               else if (retry_ff == RETRY_LAST) drop = 1'b1;
               else nxt_retry = retry_ff + 2'h1;
            end else if (good_byte) begin
               nxt_retry = 2'h0;
               nxt_rx_last = rx_byte.data;
               case (ext_idx_ff)
                  3'h0: begin
                     case (rx_byte.data)
                        scsi_msg_pkg::MSG_EXT: nxt_ext_idx = 3'h1;
                        scsi_msg_pkg::MSG_ABORT: begin
                           nxt_state = scsi_msg_pkg::ST_FREE;
                           nxt_abort = 1'b1;
                        end
                        scsi_msg_pkg::MSG_DEV_RESET: hard_clr = 1'b1;
                        scsi_msg_pkg::MSG_NOP, scsi_msg_pkg::MSG_REJECT: begin
                        end
                        scsi_msg_pkg::MSG_PAR_ERR: begin
                           start_tx = 1'b1;
                           tx_pick = last_tx_ff;
                        end
                        scsi_msg_pkg::MSG_INIT_ERR: begin
                           start_tx = 1'b1;
                           tx_pick = scsi_msg_pkg::MSG_RESTORE;
                        end
                        default: begin
                           if ((rx_byte.data & scsi_msg_pkg::IDENT_MASK) ==
                               scsi_msg_pkg::IDENT_VAL) begin
                              nxt_disc_ok = rx_byte.data[scsi_msg_pkg::IDENT_DISC_BIT];
                           end else begin
                              start_tx = 1'b1;
                           end
                        end
                     endcase
                  end
                  3'h1, 3'h2: begin
                     if (rx_byte.data == ((ext_idx_ff == 3'h1) ? scsi_msg_pkg::EXT_LEN
                                                             : scsi_msg_pkg::EXT_SYNC)) begin
                        nxt_ext_idx = ext_idx_ff + 3'h1;
                     end else begin
                        nxt_ext_idx = 3'h0;
                        start_tx = 1'b1;
                     end
                  end
                  3'h3: begin
                     nxt_ext_per = rx_byte.data;
                     nxt_ext_idx = 3'h4;
                  end
                  default: begin
                     nxt_ext_idx = 3'h0;
                     if (ext_per_ff > scsi_msg_pkg::PERIOD_MAX) begin
                        nxt_per = 8'h00;
                        nxt_off = 4'h0;
                        start_tx = 1'b1;
                     end else begin
                        // larger offsets are clipped to what the target can hold
                        off_pick = (rx_byte.data > {4'h0, scsi_msg_pkg::OFFSET_MAX}) ?
                                   scsi_msg_pkg::OFFSET_MAX : rx_byte.data[3:0];
                        nxt_off = off_pick;
                        nxt_per = (off_pick == 4'h0) ? 8'h00 : round_period(ext_per_ff);
                        start_tx = 1'b1;
                        nxt_tx_ext = 1'b1;
                     end
                  end
               endcase
            end else if (!atn_ff && ext_idx_ff == 3'h0) begin
               nxt_state = scsi_msg_pkg::ST_CONN;
            end
         end
         scsi_msg_pkg::ST_MSGI: begin
            if (last_tx) begin
               nxt_tx_valid = 1'b0;
               nxt_tx_ext = 1'b0;
               if (!tx_ext_ff && tx_single_ff == scsi_msg_pkg::MSG_CMD_DONE) begin
                  nxt_state = scsi_msg_pkg::ST_FREE;
               end else if (!tx_ext_ff && tx_single_ff == scsi_msg_pkg::MSG_REJECT) begin
                  nxt_state = scsi_msg_pkg::ST_MSGO;
               end else begin
                  nxt_state = atn_ff ? scsi_msg_pkg::ST_MSGO : scsi_msg_pkg::ST_CONN;
               end
            end else if (tx_done) begin
               nxt_tx_idx = tx_idx_ff + 3'h1;
               nxt_tx_data = reply_byte(tx_ext_ff, nxt_tx_idx, tx_single_ff, per_ff, off_ff);
            end
         end
         default: nxt_state = scsi_msg_pkg::ST_FREE;
      endcase
      // a reply is one byte, or the five-byte sync answer reflecting adopted values
      if (start_tx) begin
         nxt_state = scsi_msg_pkg::ST_MSGI;
         nxt_tx_idx = 3'h0;
         nxt_tx_len = nxt_tx_ext ? scsi_msg_pkg::EXT_BYTES : 3'h1;
         nxt_tx_single = tx_pick;
         nxt_tx_valid = 1'b1;
         nxt_tx_data = nxt_tx_ext ? scsi_msg_pkg::MSG_EXT : tx_pick;
         if (!nxt_tx_ext) nxt_last_tx = tx_pick;
      end
      // the deferred error shows on the next command if sense was not cleared through the control register
      if (new_cmd && sense_ff && !nxt_sense) nxt_check = 1'b0;
      else if (new_cmd && sense_ff) begin
         nxt_check = 1'b1;
         nxt_deferred = 1'b1;
      end
      if (drop) begin
         nxt_state = scsi_msg_pkg::ST_FREE;
         nxt_sense = 1'b1;
         nxt_retry = 2'h0;
      end
      if (brst_ff) hard_clr = 1'b1;
      if (hard_clr) begin
         nxt_state = scsi_msg_pkg::ST_FREE;
         nxt_abort = 1'b1;
         nxt_resv = 1'b0;
         nxt_per = 8'h00;
         nxt_off = 4'h0;
         nxt_disc_ok = 1'b0;
         nxt_ext_idx = 3'h0;
         nxt_retry = 2'h0;
         nxt_tx_valid = 1'b0;
         nxt_tx_ext = 1'b0;
      end
      // write-back counter is outside the clear so acked data still reaches tape
      nxt_pend = pend_ff + PEND_W'(wr_acked) - PEND_W'(wr_written && pend_ff != '0);
      nxt_phase = '0;
      case (nxt_state)
         scsi_msg_pkg::ST_CONN: nxt_phase = '{bsy: 1'b1, cd: 1'b0, io: 1'b0, msg: 1'b0};
         scsi_msg_pkg::ST_MSGO: nxt_phase = '{bsy: 1'b1, cd: 1'b1, io: 1'b0, msg: 1'b1};
         scsi_msg_pkg::ST_MSGI: nxt_phase = '{bsy: 1'b1, cd: 1'b1, io: 1'b1, msg: 1'b1};
         default: nxt_phase = '0;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= scsi_msg_pkg::ST_FREE;
         ext_idx_ff <= 3'h0;
         ext_per_ff <= 8'h00;
         tx_idx_ff <= 3'h0;
         tx_len_ff <= 3'h1;
         tx_ext_ff <= 1'b0;
         tx_single_ff <= 8'h00;
         per_ff <= 8'h00;
         off_ff <= 4'h0;
         retry_ff <= 2'h0;
         rx_last_ff <= 8'h00;
         last_tx_ff <= scsi_msg_pkg::MSG_REJECT;
         disc_ok_ff <= 1'b0;
         resv_ff <= 1'b0;
         sense_ff <= 1'b0;
         pend_ff <= '0;
         phase <= '0;
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
         check_cond <= 1'b0;
         deferred <= 1'b0;
         abort_cmd <= 1'b0;
         commit_pending <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         ext_idx_ff <= nxt_ext_idx;
         ext_per_ff <= nxt_ext_per;
         tx_idx_ff <= nxt_tx_idx;
         tx_len_ff <= nxt_tx_len;
         tx_ext_ff <= nxt_tx_ext;
         tx_single_ff <= nxt_tx_single;
         per_ff <= nxt_per;
         off_ff <= nxt_off;
         retry_ff <= nxt_retry;
         rx_last_ff <= nxt_rx_last;
         last_tx_ff <= nxt_last_tx;
         disc_ok_ff <= nxt_disc_ok;
         resv_ff <= nxt_resv;
         sense_ff <= nxt_sense;
         pend_ff <= nxt_pend;
         phase <= nxt_phase;
         tx_valid <= nxt_tx_valid;
         tx_data <= nxt_tx_data;
         check_cond <= nxt_check;
         deferred <= nxt_deferred;
         abort_cmd <= nxt_abort;
         commit_pending <= (nxt_pend != '0);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: data latched in setup, so pready rises in the first access cycle
   scsi_msg_pkg::apb_rsp_s nxt_rsp;
   always_comb begin
      nxt_rsp = '0;
      nxt_rsp.pready = apb_req.psel && !apb_req.penable;
      case (apb_req.paddr)
         scsi_msg_pkg::REG_CTRL: nxt_rsp.prdata[scsi_msg_pkg::CTRL_RESV_BIT] = resv_ff;
         scsi_msg_pkg::REG_STAT: begin
            nxt_rsp.prdata[scsi_msg_pkg::STAT_BSY_BIT] = phase.bsy;
            nxt_rsp.prdata[scsi_msg_pkg::STAT_SENSE_BIT] = sense_ff;
            nxt_rsp.prdata[scsi_msg_pkg::STAT_DISC_BIT] = disc_ok_ff;
            nxt_rsp.prdata[scsi_msg_pkg::STAT_RESV_BIT] = resv_ff;
            nxt_rsp.prdata[scsi_msg_pkg::STAT_OFF_LSB +: 4] = off_ff;
            nxt_rsp.prdata[scsi_msg_pkg::STAT_PER_LSB +: 8] = per_ff;
            nxt_rsp.prdata[scsi_msg_pkg::STAT_LAST_LSB +: 8] = rx_last_ff;
         end
         scsi_msg_pkg::REG_SENSE: begin
            if (sense_ff) begin
               nxt_rsp.prdata[3:0] = scsi_msg_pkg::SENSE_KEY;
               nxt_rsp.prdata[scsi_msg_pkg::SENSE_ASC_LSB +: 8] = scsi_msg_pkg::SENSE_ASC;
               nxt_rsp.prdata[scsi_msg_pkg::SENSE_ASCQ_LSB +: 8] = scsi_msg_pkg::SENSE_ASCQ;
            end
         end
         default: nxt_rsp.pslverr = nxt_rsp.pready; // unmapped answers with error
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) apb_rsp <= '0;
      else apb_rsp <= nxt_rsp;
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   AST_MSGO_LINES: assert property (state_ff == scsi_msg_pkg::ST_MSGO |->
      phase.cd && phase.msg && !phase.io && phase.bsy) else $error("message out lines wrong");
   AST_MSGI_LINES: assert property (state_ff == scsi_msg_pkg::ST_MSGI |->
      phase.cd && phase.msg && phase.io && tx_valid) else $error("message in lines wrong");
   AST_SEL_ATN: assert property (state_ff == scsi_msg_pkg::ST_FREE && sel_done && atn_ff &&
      !brst_ff |=> state_ff == scsi_msg_pkg::ST_MSGO) else $error("no message out after select");
   AST_BUS_RESET: assert property (brst_ff |=> state_ff == scsi_msg_pkg::ST_FREE &&
      !phase.bsy && abort_cmd && off_ff == 4'h0 && !resv_ff) else $error("bus reset ignored");
   AST_RETRY_STAY: assert property (bad_byte && prty_ff && retry_ff == 2'h0 && !brst_ff
      |=> state_ff == scsi_msg_pkg::ST_MSGO && retry_ff == 2'h1) else $error("retry lost");
   AST_RETRY_DROP: assert property (bad_byte && prty_ff && retry_ff == 2'h2
      |=> state_ff == scsi_msg_pkg::ST_FREE && sense_ff) else $error("third parity miss kept");
   AST_CHECK_DROP: assert property (bad_byte && !prty_ff |=>
      state_ff == scsi_msg_pkg::ST_FREE && sense_ff ##1 !phase.bsy) else $error("check drop");
   AST_CC_FREE: assert property (state_ff == scsi_msg_pkg::ST_MSGI && last_tx && !tx_ext_ff
      && tx_single_ff == 8'h00 |=> state_ff == scsi_msg_pkg::ST_FREE) else $error("cc no free");
   AST_REJECT_BACK: assert property (state_ff == scsi_msg_pkg::ST_MSGI && last_tx && !brst_ff
      && !tx_ext_ff && tx_single_ff == 8'h07 |=> state_ff == scsi_msg_pkg::ST_MSGO)
      else $error("reject not followed by message out");
   AST_SYNC_RANGE: assert property (off_ff <= 4'hF && (off_ff == 4'h0) == (per_ff == 8'h00)
      && (per_ff == 8'h00 || (per_ff >= 8'h34 && per_ff <= 8'hFA))) else $error("bad sync");
   AST_DEFER: assert property (new_cmd && sense_ff && !wr_hit |=> check_cond && deferred)
      else $error("deferred error not shown");
   AST_WR_KEEP: assert property (brst_ff && pend_ff != '0 && !wr_written |=> commit_pending)
      else $error("write back lost on reset");

   COV_SYNC: cover property (state_ff == scsi_msg_pkg::ST_MSGI && tx_ext_ff && last_tx);
   COV_RETRY_DROP: cover property (bad_byte && prty_ff && retry_ff == 2'h2);
   COV_REJECT: cover property (start_tx && tx_pick == scsi_msg_pkg::MSG_REJECT);
   COV_CC: cover property (state_ff == scsi_msg_pkg::ST_MSGI ##1 state_ff == scsi_msg_pkg::ST_FREE);

endmodule
`default_nettype wire

// File: test/scsi_init_model.sv
`timescale 1ns/10ps
`default_nettype none
// initiator: takes each message-in byte after a 0..3 cycle stall
module scsi_init_model (
   input wire logic clk,
   input wire logic tx_valid,
   output logic tx_done
);
   initial begin
      tx_done = 1'b0;
      forever begin
         @(posedge clk);
         if (tx_valid === 1'b1) begin
            repeat ($urandom % 4) @(posedge clk);
            tx_done <= 1'b1;
            @(posedge clk);
            tx_done <= 1'b0;
            @(posedge clk);
         end
      end
   end
endmodule
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clk, rstn, atn, brst, pty, seld, cmpl, ncmd, wack, wwr, tx_done, tx_valid, err;
   logic check_cond, deferred, commit_pending, abort_cmd;
   logic [7:0] tx_data;
   logic [31:0] rd;
   int n_mismatch = 0, n_checks = 0, cyc = 0;
   logic [7:0] expq [$];
   scsi_msg_pkg::apb_req_s req;
   scsi_msg_pkg::apb_rsp_s rsp;
   scsi_msg_pkg::rx_byte_s rx;
   scsi_msg_pkg::phase_s ph;
   scsi_target_msg uut (.clk(clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp), .atn_pin(atn),
      .bus_rst_pin(brst), .parity_retry_pin(pty), .sel_done(seld), .cmd_complete(cmpl),
      .new_cmd(ncmd), .rx_byte(rx), .tx_done(tx_done), .wr_acked(wack), .wr_written(wwr),
      .phase(ph), .tx_valid(tx_valid), .tx_data(tx_data), .check_cond(check_cond),
      .deferred(deferred), .abort_cmd(abort_cmd), .commit_pending(commit_pending));
   scsi_init_model peer (.clk(clk), .tx_valid(tx_valid), .tx_done(tx_done));
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // hang guard, far above the run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         summarize();
      end
   end
   // each accepted byte against the oldest note
   always @(posedge clk) begin
      if (tx_valid === 1'b1 && tx_done === 1'b1) begin
         chk("tx_phase", 4'hF, ph);
         chk("tx_data", expq.size() ? expq.pop_front() : 8'hxx, tx_data);
      end
   end
   task automatic tick(int n);
      repeat (n) @(posedge clk);
   endtask
   // apb master: no wait count assumed, holds until pready
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      req.penable <= 1'b1;
      // if pready never rises, only the hang guard ends this wait
      do begin
         @(posedge clk);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
   endtask
   task automatic send(logic [7:0] d, logic ok);
      @(posedge clk);
      rx <= '{1'b1, ok, d};
      @(posedge clk);
      rx <= '0;
   endtask
   task automatic drain(logic [3:0] p);
      for (int k = 0; k < 300 && expq.size() != 0; k++) @(posedge clk);
      tick(3);
      chk("queue", 0, expq.size());
      chk("phase", p, ph);
   endtask
   task automatic connect();
      atn <= 1'b1;
      tick(3);
      seld <= 1'b1;
      @(posedge clk);
      seld <= 1'b0;
      tick(3);
      chk("phase", 4'hD, ph);
      send(8'hC0, 1'b1);
      tick(2);
   endtask
   initial begin
      logic [7:0] bad [6] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h0A, 8'h0B};
      logic [7:0] rty [2] = '{8'h05, 8'h09};
      logic [7:0] gone [2] = '{8'h0C, 8'h06};
      logic [7:0] ext [5];
      logic [7:0] p, o;
      {rstn, atn, brst, seld, cmpl, ncmd, wack, wwr} = '0;
      pty = 1'b1;
      req = '0;
      rx = '0;
      void'($urandom(32'h006d_33c2));
      tick(10);
      rstn <= 1'b1;
      apb(1'b0, 8'h0C, 0);
      chk("slverr", 1, err);
      connect();
      apb(1'b0, 8'h04, 0);
      chk("disc", 1, rd[2]);
      foreach (bad[i]) begin
         expq.push_back(8'h07);
         send(bad[i], 1'b1);
         drain(4'hD);
      end
      // initiator error asks for restore; parity error repeats that last byte
      foreach (rty[i]) begin
         expq.push_back(8'h03);
         send(rty[i], 1'b1);
         drain(4'hD);
      end
      for (int i = 0; i < 4; i++) begin
         p = (i == 3) ? 8'hFB : scsi_msg_pkg::PERIOD_TAB[$urandom % 20];
         o = 8'($urandom % 32);
         if (i == 3)
            expq.push_back(8'h07);
         else
            expq = {expq, 8'h01, 8'h03, 8'h01, o ? p : 8'h00, o > 15 ? 8'h0F : o};
         ext = '{8'h01, 8'h03, 8'h01, p, o};
         foreach (ext[j]) send(ext[j], 1'b1);
         drain(4'hD);
      end
      apb(1'b0, 8'h04, 0);
      chk("period", 0, rd[23:16]);
      $display("message codes done");
      repeat (3) send(8'h08, 1'b0);
      tick(3);
      chk("phase", 0, ph);
      apb(1'b0, 8'h08, 0);
      chk("sense", 32'h0003_430B, rd);
      ncmd <= 1'b1;
      @(posedge clk);
      ncmd <= 1'b0;
      @(posedge clk);
      chk("check", 2'b11, {check_cond, deferred});
      pty <= 1'b0;
      connect();
      send(8'h08, 1'b0);
      tick(3);
      chk("phase", 0, ph);
      $display("parity done");
      connect();
      apb(1'b1, 8'h00, 32'h0000_0001);
      wack <= 1'b1;
      @(posedge clk);
      wack <= 1'b0;
      brst <= 1'b1;
      tick(6);
      brst <= 1'b0;
      tick(4);
      chk("phase", 0, ph);
      chk("commit", 1, commit_pending);
      wwr <= 1'b1;
      @(posedge clk);
      wwr <= 1'b0;
      tick(2);
      chk("commit", 0, commit_pending);
      apb(1'b0, 8'h04, 0);
      chk("modes", 0, rd[23:3]);
      connect();
      atn <= 1'b0;
      tick(4);
      expq.push_back(8'h00);
      cmpl <= 1'b1;
      @(posedge clk);
      cmpl <= 1'b0;
      drain(4'h0);
      // device reset and abort both pulse abort and free the bus
      foreach (gone[i]) begin
         connect();
         send(gone[i], 1'b1);
         @(posedge clk);
         chk("abort", 1, abort_cmd);
         tick(2);
         chk("phase", 0, ph);
      end
      $display("resets done");
      summarize();
   end
endmodule
`default_nettype wire
